// *** core/rxc_pkg.sv ***
// What this block does
// (R1) Each processed receive request leaves one completion word in a four-entry queue.
// (R2) Head entry signals its thread once; a completion read pops it.
// (R3) Full queue stalls the engine and refuses new receive requests.
// (R4) Explicit thread mode (ready control 14:13 = 10) puts MAC port in id field.
// (R5) Sequence field: fast-port number with start of packet, else MAC packet number.
// (R6) Abort input sets fail flag, ends the request, skips status.
// (R7) Error flag is inverted status bit 8 when status is captured.
// (R8) Word reports first element, copy of second element, one-or-two elements filled.
// (R9) Port-select bit tells fast port 1 or fast port 2.
// (R10) Valid-byte field holds byte count minus one when end of packet seen.
// (R11) Start/end flags recorded; fast-port start of packet bumps port sequence.
// (R12) Header-body mode: header thread at start, next request latches body thread.
// (R13) Single-thread mode: start of packet latches thread id, later requests reuse it.
// (R14) Eight bytes per data cycle bidirectional, four unidirectional; at end of packet byte enables give count.
// (R15) Transmit drives byte enables from last-quadword and last-byte counts.
// (R16) Bidirectional: one 8-bit enable bus; unidirectional: 3:0 receive, 7:4 transmit.
// (R17) Endian bit picks big or little byte order within each longword.
// (R18) 64-bit enables: F7..00 big endian, FE..00 little endian.
// (R19) 32-bit enables: 7,3,1,0 big endian, E,C,8,0 little endian.
// (R20) Element k: data quadwords 8(k-1).., extended 128+2(k-1), status 129+2(k-1).
// (R21) Per-request bit gathers a ninth quadword into the extended field.
// (R22) Extra quadword unavailable in 32-bit unidirectional mode with 64-bit status.
// (R23) Status after end of packet: quadword bidirectional, longword or quadword unidirectional.
package rxc_pkg;
   localparam int TID_W = 5;
   localparam int ELEM_W = 4;
   localparam int SEQ_W = 4;
   localparam int QDEPTH = 4;
   localparam int Q_AW = 2;
   localparam logic [2:0] QFULL = 3'h4;
   localparam logic [7:0] OFF_COMPLETION = 8'h00;
   localparam logic [7:0] OFF_READY_CTL = 8'h04;
   localparam logic [7:0] OFF_TEMPLATE = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam int FPM_HI = 14;
   localparam int FPM_LO = 13;
   localparam int TPL_BIG = 0;
   localparam int TPL_BIDIR = 1;
   localparam int TPL_STAT_EN = 2;
   localparam logic TPL_BIG_RST = 1'h0;
   localparam logic TPL_BIDIR_RST = 1'h1;
   localparam logic TPL_STAT_EN_RST = 1'h0;
   localparam int STAT_OK_BIT = 8;
   localparam logic [7:0] EXT_BASE = 8'h80;
   localparam logic [7:0] STAT_BASE = 8'h81;
   localparam logic [4:0] QW_ONE = 5'h08;
   localparam logic [4:0] QW_XQ = 5'h09;
   localparam logic [4:0] QW_TWO = 5'h10;
   localparam logic [7:0] BYTES_QW = 8'h08;
   localparam logic [7:0] BYTES_LW = 8'h04;
   localparam logic [1:0] PORT_SLOW = 2'h0;
   localparam logic [1:0] PORT_FAST2 = 2'h2;

   typedef enum logic [1:0] {
      FPM_HDR_BODY = 2'b00,
      FPM_SINGLE = 2'b01,
      FPM_EXPLICIT = 2'b10,
      FPM_RSVD = 2'b11
   } fp_mode_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_DATA = 4'b0010,
      S_STAT = 4'b0100,
      S_PUSH = 4'b1000
   } rx_state_t;

   typedef struct packed {
      logic eop;
      logic sop;
      logic [TID_W-1:0] id;
      logic [SEQ_W-1:0] seq;
      logic fail;
      logic err;
      logic [ELEM_W-1:0] second_elem;
      logic [ELEM_W-1:0] first_elem;
      logic elems_two;
      logic fast_port2;
      logic extra_qw;
      logic [7:0] valid_bytes;
   } completion_t;

   typedef struct packed {
      completion_t word;
      logic [TID_W-1:0] target_thread_id;
   } cq_entry_t;

   // Active-low enables for n valid bytes; big endian mirrors lanes per longword
   function automatic logic [7:0] be_encode(input logic [3:0] n, input logic big);
      logic [7:0] be;
      logic [2:0] pos;
      be = 8'hff;
      for (int i = 0; i < 8; i++)
      begin
         pos = 3'(i);
         if (big)
            pos = {pos[2], ~pos[1:0]}; // (R17)
         be[i] = ({1'b0, pos} >= n); // (R18) (R19)
      end
      return be;
   endfunction

   // Valid bytes in the enabled lanes
   function automatic logic [7:0] be_count(input logic [7:0] be_n, input logic four);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 8; i++)
         if (!be_n[i] && (!four || i < 4))
            c = c + 8'h01;
      return c;
   endfunction
endpackage

// *** core/cq_if.sv ***
interface cq_if;
   import rxc_pkg::*;
   logic push;
   cq_entry_t push_data;
   logic pop;
   logic full;
   logic valid;
   cq_entry_t head;
   logic [2:0] count;
   modport fill (output push, push_data, pop, input full, valid, head, count);
   modport queue (input push, push_data, pop, output full, valid, head, count);
endinterface

// *** core/completion_queue.sv ***
module completion_queue (
   input wire logic clk,
   input wire logic rst,
   cq_if.queue q
);
   import rxc_pkg::*;
   cq_entry_t mem [QDEPTH];
   cq_entry_t head_reg;
   logic [Q_AW-1:0] wp_reg;
   logic [Q_AW-1:0] rp_reg;
   logic [Q_AW-1:0] rp_next;
   logic [2:0] count_reg;
   logic do_push;
   logic do_pop;

   assign do_push = q.push & ~q.full; // (R1)
   assign do_pop = q.pop & q.valid; // (R2)
   assign rp_next = do_pop ? rp_reg + 2'h1 : rp_reg;
   assign q.full = (count_reg == QFULL);
   assign q.valid = (count_reg != 3'h0);
   assign q.head = head_reg;
   assign q.count = count_reg;

   always_ff @(posedge clk)
      if (do_push)
         mem[wp_reg] <= q.push_data;

   always_ff @(posedge clk or posedge rst)
      if (rst)
      begin
         wp_reg <= '0;
         rp_reg <= '0;
         count_reg <= 3'h0;
      end
      else
      begin
         rp_reg <= rp_next;
         if (do_push)
            wp_reg <= wp_reg + 2'h1;
         if (do_push && !do_pop)
            count_reg <= count_reg + 3'h1;
         else if (do_pop && !do_push)
            count_reg <= count_reg - 3'h1;
      end

   // Head register follows the next read pointer, bypassing a fresh write
   always_ff @(posedge clk or posedge rst)
      if (rst)
         head_reg <= '0;
      else if (do_push && wp_reg == rp_next)
         head_reg <= q.push_data;
      else
         head_reg <= mem[rp_next];
endmodule

// *** core/rx_completion.sv ***
module rx_completion (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire logic [rxc_pkg::TID_W-1:0] REQ_TID,
   input wire logic [rxc_pkg::TID_W-1:0] REQ_PORT,
   input wire logic [1:0] REQ_FAST,
   input wire logic [rxc_pkg::ELEM_W-1:0] REQ_E1,
   input wire logic [rxc_pkg::ELEM_W-1:0] REQ_E2,
   input wire logic REQ_TWO,
   input wire logic REQ_XQ,
   input wire logic REQ_STAT_QW,
   input wire logic [rxc_pkg::SEQ_W-1:0] REQ_PKT_SEQ,
   input wire logic RX_VALID,
   input wire logic RX_SOP,
   input wire logic RX_EOP,
   input wire logic RX_ABORT,
   input wire logic [63:0] RX_BUS_DATA,
   input wire logic [7:0] BYTE_ENABLE_N_IN,
   output logic [7:0] BYTE_ENABLE_N_OUT,
   output logic [7:0] BYTE_ENABLE_OE,
   input wire logic TX_ACTIVE,
   input wire logic TX_LAST_QW,
   input wire logic [2:0] TX_LAST_BYTES,
   output logic BUF_WE,
   output logic [7:0] BUF_ADDR,
   output logic [63:0] BUF_WDATA,
   output logic SIG_VALID,
   output logic [rxc_pkg::TID_W-1:0] SIG_TID
);
   import rxc_pkg::*;

   cq_if cq ();

   completion_queue u_queue (
      .clk(CLOCK),
      .rst(RST),
      .q(cq.queue)
   );

   fp_mode_t fp_mode_reg;
   logic big_reg;
   logic bidir_reg;
   logic stat_en_reg;
   logic pready_reg;
   logic rd_valid_reg;
   logic signalled_reg;
   rx_state_t state_reg;
   rx_state_t state_next;
   logic [TID_W-1:0] tid_reg;
   logic [TID_W-1:0] port_reg;
   logic [1:0] fast_reg;
   logic [ELEM_W-1:0] e1_reg;
   logic [ELEM_W-1:0] e2_reg;
   logic two_reg;
   logic xq_reg;
   logic statqw_reg;
   logic [SEQ_W-1:0] pseq_reg;
   logic [4:0] qi_reg;
   logic half_reg;
   logic [31:0] lo_reg;
   logic [7:0] bc_reg;
   logic sop_reg;
   logic eop_reg;
   logic fail_reg;
   logic err_reg;
   logic ef_reg;
   logic xqdone_reg;
   logic [TID_W-1:0] hdr_tid_reg [2];
   logic [TID_W-1:0] lat_tid_reg [2];
   logic [SEQ_W-1:0] fp_seq_reg [2];
   logic body_next_reg [2];
   logic setup_acc;
   logic done_acc;
   logic rx_end;
   logic qw_write;
   logic last_qw;
   logic stat_last;
   logic [4:0] limit;
   logic [7:0] add_bytes;
   logic [7:0] qaddr;
   logic [63:0] wdata;
   logic p;
   logic is_fast;
   logic hb_mode;
   logic [TID_W-1:0] sig_tid;
   completion_t word;

   // APB slave with one wait state so read data leaves a flop
   assign setup_acc = PSEL & PENABLE & ~pready_reg;
   assign done_acc = PSEL & PENABLE & pready_reg;
   assign PREADY = pready_reg;

   always_ff @(posedge CLOCK or posedge RST)
      if (RST)
      begin
         pready_reg <= 1'b0;
         rd_valid_reg <= 1'b0;
         PRDATA <= 32'h0;
         PSLVERR <= 1'b0;
      end
      else
      begin
         pready_reg <= setup_acc;
         if (setup_acc)
         begin
            PSLVERR <= 1'b0;
            rd_valid_reg <= 1'b0;
            PRDATA <= 32'h0;
            unique case (PADDR)
               OFF_COMPLETION:
               begin
                  rd_valid_reg <= cq.valid & ~PWRITE;
                  if (cq.valid)
                     PRDATA <= cq.head.word;
               end
               OFF_READY_CTL:
                  PRDATA[FPM_HI:FPM_LO] <= fp_mode_reg;
               OFF_TEMPLATE:
               begin
                  PRDATA[TPL_BIG] <= big_reg;
                  PRDATA[TPL_BIDIR] <= bidir_reg;
                  PRDATA[TPL_STAT_EN] <= stat_en_reg;
               end
               OFF_STATUS:
                  PRDATA[11:0] <= {fp_seq_reg[1], fp_seq_reg[0],
                     state_reg != S_IDLE, cq.count};
               default:
                  PSLVERR <= 1'b1;
            endcase
         end
      end

   assign cq.pop = done_acc & ~PWRITE & rd_valid_reg; // (R2)

   always_ff @(posedge CLOCK or posedge RST)
      if (RST)
      begin
         fp_mode_reg <= FPM_HDR_BODY;
         big_reg <= TPL_BIG_RST;
         bidir_reg <= TPL_BIDIR_RST;
         stat_en_reg <= TPL_STAT_EN_RST;
      end
      else if (done_acc && PWRITE)
      begin
         if (PADDR == OFF_READY_CTL)
            fp_mode_reg <= fp_mode_t'(PWDATA[FPM_HI:FPM_LO]);
         if (PADDR == OFF_TEMPLATE)
         begin
            big_reg <= PWDATA[TPL_BIG];
            bidir_reg <= PWDATA[TPL_BIDIR];
            stat_en_reg <= PWDATA[TPL_STAT_EN];
         end
      end

   // One signal per entry reaching the head
   always_ff @(posedge CLOCK or posedge RST)
      if (RST)
      begin
         signalled_reg <= 1'b0;
         SIG_VALID <= 1'b0;
         SIG_TID <= '0;
      end
      else
      begin
         SIG_VALID <= 1'b0;
         if (cq.pop)
            signalled_reg <= 1'b0;
         else if (cq.valid && !signalled_reg)
         begin
            SIG_VALID <= 1'b1; // (R2)
            SIG_TID <= cq.head.target_thread_id;
            signalled_reg <= 1'b1;
         end
      end

   assign REQ_READY = (state_reg == S_IDLE) & ~cq.full; // (R3)

   assign rx_end = RX_EOP | RX_ABORT;
   assign qw_write = bidir_reg | half_reg | rx_end;
   assign limit = two_reg ? QW_TWO : xq_reg ? QW_XQ : QW_ONE;
   assign last_qw = qw_write & (qi_reg + 5'h01 == limit);
   assign stat_last = bidir_reg | ~statqw_reg | half_reg; // (R23)

   always_comb
   begin
      if (RX_ABORT)
         add_bytes = 8'h00;
      else if (RX_EOP)
         add_bytes = be_count(BYTE_ENABLE_N_IN, ~bidir_reg); // (R14) (R16)
      else
         add_bytes = bidir_reg ? BYTES_QW : BYTES_LW; // (R14)
   end

   // Buffer quadword address of the current beat
   always_comb
   begin
      if (state_reg == S_STAT)
         qaddr = (!bidir_reg && statqw_reg && !half_reg) ?
            EXT_BASE | {3'h0, e1_reg, 1'b0} : STAT_BASE | {3'h0, e1_reg, 1'b0}; // (R20)
      else if (qi_reg[3] && xq_reg)
         qaddr = EXT_BASE | {3'h0, e1_reg, 1'b0}; // (R21)
      else if (qi_reg[3])
         qaddr = {1'b0, e2_reg, qi_reg[2:0]}; // (R20)
      else
         qaddr = {1'b0, e1_reg, qi_reg[2:0]}; // (R20)
   end

   always_comb
   begin
      if (bidir_reg)
         wdata = RX_BUS_DATA;
      else if (half_reg && state_reg == S_DATA)
         wdata = {RX_BUS_DATA[31:0], lo_reg};
      else
         wdata = {32'h0, RX_BUS_DATA[31:0]};
   end

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         S_IDLE:
            if (REQ_VALID && REQ_READY)
               state_next = S_DATA;
         S_DATA:
            if (RX_VALID && RX_ABORT)
               state_next = S_PUSH; // (R6)
            else if (RX_VALID && RX_EOP && stat_en_reg)
               state_next = S_STAT; // (R23)
            else if (RX_VALID && (RX_EOP || last_qw))
               state_next = S_PUSH;
         S_STAT:
            if (RX_VALID && stat_last)
               state_next = S_PUSH;
         S_PUSH:
            if (!cq.full)
               state_next = S_IDLE; // (R3)
      endcase
   end

   always_ff @(posedge CLOCK or posedge RST)
      if (RST)
         state_reg <= S_IDLE;
      else
         state_reg <= state_next;

   // Request capture and receive datapath
   always_ff @(posedge CLOCK or posedge RST)
      if (RST)
      begin
         {tid_reg, port_reg, fast_reg, e1_reg, e2_reg} <= '0;
         {two_reg, xq_reg, statqw_reg, pseq_reg} <= '0;
         {qi_reg, half_reg, lo_reg, bc_reg} <= '0;
         {sop_reg, eop_reg, fail_reg, err_reg, ef_reg, xqdone_reg} <= '0;
         BUF_WE <= 1'b0;
         BUF_ADDR <= 8'h00;
         BUF_WDATA <= 64'h0;
      end
      else
      begin
         BUF_WE <= 1'b0;
         if (state_reg == S_IDLE && REQ_VALID && REQ_READY)
         begin
            tid_reg <= REQ_TID;
            port_reg <= REQ_PORT;
            fast_reg <= REQ_FAST;
            e1_reg <= REQ_E1;
            e2_reg <= REQ_E2; // (R8)
            two_reg <= REQ_TWO;
            xq_reg <= REQ_XQ & ~REQ_TWO & ~(~bidir_reg & REQ_STAT_QW); // (R22)
            statqw_reg <= REQ_STAT_QW;
            pseq_reg <= REQ_PKT_SEQ;
            {qi_reg, half_reg, bc_reg} <= '0;
            {sop_reg, eop_reg, fail_reg, err_reg, ef_reg, xqdone_reg} <= '0;
         end
         if (state_reg == S_DATA && RX_VALID)
         begin
            bc_reg <= bc_reg + add_bytes; // (R14)
            sop_reg <= sop_reg | RX_SOP; // (R11)
            eop_reg <= eop_reg | (RX_EOP & ~RX_ABORT); // (R11)
            fail_reg <= fail_reg | RX_ABORT; // (R6)
            if (!qw_write)
            begin
               lo_reg <= RX_BUS_DATA[31:0];
               half_reg <= 1'b1;
            end
            else if (!RX_ABORT)
            begin
               BUF_WE <= 1'b1;
               BUF_ADDR <= qaddr;
               BUF_WDATA <= wdata;
               qi_reg <= qi_reg + 5'h01;
               half_reg <= 1'b0;
               if (qi_reg[3] && two_reg)
                  ef_reg <= 1'b1; // (R8)
               if (qi_reg[3] && xq_reg)
                  xqdone_reg <= 1'b1; // (R21)
            end
         end
         if (state_reg == S_STAT && RX_VALID)
         begin
            BUF_WE <= 1'b1; // (R23)
            BUF_ADDR <= qaddr;
            BUF_WDATA <= wdata;
            half_reg <= ~stat_last;
            if (!half_reg)
               err_reg <= ~RX_BUS_DATA[STAT_OK_BIT]; // (R7)
         end
      end

   // Thread choice, id field and sequence numbering
   assign p = (fast_reg == PORT_FAST2);
   assign is_fast = (fast_reg != PORT_SLOW);
   assign hb_mode = (fp_mode_reg == FPM_HDR_BODY) | (fp_mode_reg == FPM_RSVD);

   always_comb
   begin
      sig_tid = tid_reg;
      if (is_fast && !sop_reg)
         unique case (fp_mode_reg)
            FPM_HDR_BODY, FPM_RSVD:
               if (!body_next_reg[p])
                  sig_tid = lat_tid_reg[p]; // (R12)
            FPM_SINGLE:
               sig_tid = lat_tid_reg[p]; // (R13)
            FPM_EXPLICIT:
               sig_tid = tid_reg;
         endcase
   end

   always_comb
   begin
      word.eop = eop_reg;
      word.sop = sop_reg;
      word.id = tid_reg;
      if (is_fast)
         word.id = (fp_mode_reg == FPM_EXPLICIT || sop_reg) ?
            port_reg : hdr_tid_reg[p]; // (R4)
      word.seq = (is_fast && sop_reg) ? fp_seq_reg[p] : pseq_reg; // (R5)
      word.fail = fail_reg; // (R6)
      word.err = stat_en_reg & ~fail_reg & err_reg; // (R7)
      word.second_elem = e2_reg;
      word.first_elem = e1_reg;
      word.elems_two = ef_reg;
      word.fast_port2 = is_fast & p; // (R9)
      word.extra_qw = xqdone_reg;
      word.valid_bytes = bc_reg - 8'h01; // (R10)
   end

   assign cq.push = (state_reg == S_PUSH) & ~cq.full; // (R1)
   assign cq.push_data = '{word: word, target_thread_id: sig_tid};

   always_ff @(posedge CLOCK or posedge RST)
      if (RST)
         for (int i = 0; i < 2; i++)
         begin
            hdr_tid_reg[i] <= '0;
            lat_tid_reg[i] <= '0;
            fp_seq_reg[i] <= '0;
            body_next_reg[i] <= 1'b0;
         end
      else if (cq.push && is_fast)
      begin
         if (sop_reg)
         begin
            fp_seq_reg[p] <= fp_seq_reg[p] + 4'h1; // (R11)
            hdr_tid_reg[p] <= tid_reg;
            lat_tid_reg[p] <= tid_reg; // (R13)
            body_next_reg[p] <= hb_mode; // (R12)
         end
         else if (hb_mode && body_next_reg[p])
         begin
            lat_tid_reg[p] <= tid_reg; // (R12)
            body_next_reg[p] <= 1'b0;
         end
      end

   // Transmit byte enables; unidirectional uses the upper nibble
   always_ff @(posedge CLOCK or posedge RST)
      if (RST)
      begin
         BYTE_ENABLE_N_OUT <= 8'hff;
         BYTE_ENABLE_OE <= 8'h00;
      end
      else if (!TX_ACTIVE)
      begin
         BYTE_ENABLE_N_OUT <= 8'hff;
         BYTE_ENABLE_OE <= 8'h00;
      end
      else if (bidir_reg)
      begin
         BYTE_ENABLE_N_OUT <= TX_LAST_QW ?
            be_encode({1'b0, TX_LAST_BYTES} + 4'h1, big_reg) : 8'h00; // (R15) (R18)
         BYTE_ENABLE_OE <= 8'hff; // (R16)
      end
      else
      begin
         BYTE_ENABLE_N_OUT[7:4] <= TX_LAST_QW ?
            4'(be_encode({2'h0, TX_LAST_BYTES[1:0]} + 4'h1, big_reg)) : 4'h0; // (R19)
         BYTE_ENABLE_N_OUT[3:0] <= 4'hf;
         BYTE_ENABLE_OE <= 8'hf0; // (R16)
      end
endmodule

// *** verif/mac_model.sv ***
module mac_model (
   input wire logic CLOCK,
   output logic RX_VALID,
   output logic RX_SOP,
   output logic RX_EOP,
   output logic RX_ABORT,
   output logic [63:0] RX_BUS_DATA,
   output logic [7:0] BYTE_ENABLE_N_IN
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      {RX_VALID, RX_SOP, RX_EOP, RX_ABORT} = 4'h0;
      RX_BUS_DATA = 64'h0;
      BYTE_ENABLE_N_IN = 8'hff;
   end

   task automatic frame(input int n, input logic sop, input logic [7:0] be, input int ab,
                        input logic st_en, input logic [63:0] st);
      for (int i = 1; i <= n; i++)
      begin
         RX_VALID <= 1'b1;
         RX_SOP <= sop && i == 1;
         RX_EOP <= i == n;
         RX_ABORT <= i == ab;
         RX_BUS_DATA <= {8{8'(i)}};
         BYTE_ENABLE_N_IN <= (i == n) ? be : ~be;
         @(posedge CLOCK);
         if (i == ab)
            break;
      end
      if (st_en && ab == 0)
      begin
         {RX_SOP, RX_EOP, RX_ABORT} <= 3'h0;
         RX_BUS_DATA <= st;
         @(posedge CLOCK);
      end
      // Idle lines show junk so only RX_VALID qualifies them
      RX_VALID <= 1'b0;
      {RX_SOP, RX_EOP, RX_ABORT} <= 3'h7;
      RX_BUS_DATA <= ~RX_BUS_DATA;
      BYTE_ENABLE_N_IN <= ~BYTE_ENABLE_N_IN;
   endtask
endmodule

// *** verif/rx_completion_sva.sv ***
module rx_completion_sva (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input logic PREADY,
   input wire logic REQ_VALID,
   input logic REQ_READY,
   input wire logic RX_VALID,
   input wire logic RX_ABORT,
   input logic BUF_WE,
   input logic SIG_VALID,
   input wire logic TX_ACTIVE,
   input wire logic TX_LAST_QW,
   input logic [7:0] BYTE_ENABLE_N_OUT,
   input logic [7:0] BYTE_ENABLE_OE
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);

   sequence apb_access;
      PSEL && !PENABLE ##1 PSEL && PENABLE;
   endsequence

   sequence one_wait;
      !PREADY ##1 PREADY ##1 !PREADY;
   endsequence

   apb_wait_a: assert property (apb_access |-> one_wait)
      else $error("apb answer timing wrong");
   req_busy_a: assert property (REQ_VALID && REQ_READY |=> !REQ_READY)
      else $error("request accepted while busy");
   sig_pulse_a: assert property (SIG_VALID |=> !SIG_VALID)
      else $error("thread signal longer than one cycle");
   abort_quiet_a: assert property (RX_VALID && RX_ABORT |=> !BUF_WE)
      else $error("abort beat written");
   we_cause_a: assert property (BUF_WE |-> $past(RX_VALID))
      else $error("buffer write without beat");
   tx_idle_a: assert property (!TX_ACTIVE |=> BYTE_ENABLE_OE == 8'h00 && BYTE_ENABLE_N_OUT == 8'hff)
      else $error("enables driven while idle");
   tx_full_a: assert property (TX_ACTIVE && !TX_LAST_QW |=> (BYTE_ENABLE_N_OUT & BYTE_ENABLE_OE) == 8'h00)
      else $error("full quadword not all enabled");
   tx_lanes_a: assert property (TX_ACTIVE |=> BYTE_ENABLE_OE inside {8'hff, 8'hf0})
      else $error("enable lanes wrong");
endmodule

bind rx_completion rx_completion_sva chk_u (.*);

// *** verif/test_rx_completion.sv ***
module test_rx_completion;
   timeunit 1ns;
   timeprecision 100ps;
   import rxc_pkg::*;
   logic CLOCK = 1'b0;
   logic RST = 1'b1;
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA;
   logic PREADY, PSLVERR, REQ_READY, SIG_VALID, BUF_WE;
   logic REQ_VALID = 1'b0, REQ_TWO = 1'b0, REQ_XQ = 1'b0, REQ_STAT_QW = 1'b0;
   logic [TID_W-1:0] REQ_TID = 5'h00, REQ_PORT = 5'h00, SIG_TID;
   logic [1:0] REQ_FAST = 2'h0;
   logic [ELEM_W-1:0] REQ_E1 = 4'h0, REQ_E2 = 4'h5;
   logic [SEQ_W-1:0] REQ_PKT_SEQ = 4'h0;
   logic RX_VALID, RX_SOP, RX_EOP, RX_ABORT;
   logic [63:0] RX_BUS_DATA, BUF_WDATA;
   logic [7:0] BYTE_ENABLE_N_IN, BYTE_ENABLE_N_OUT, BYTE_ENABLE_OE, BUF_ADDR;
   logic TX_ACTIVE = 1'b0, TX_LAST_QW = 1'b0;
   logic [2:0] TX_LAST_BYTES = 3'h0;
   int errors = 0;
   int checks = 0;
   int k;
   logic [31:0] rdat;
   logic slv;
   logic [7:0] last_addr = 8'h00;
   logic [63:0] last_dat;
   logic [63:0] big_t = 64'hf7f3f1f0_70301000;
   logic [63:0] lit_t = 64'hfefcf8f0_e0c08000;

   rx_completion dut_u (.*);
   mac_model mac_u (.*);

   always #2.5 CLOCK = ~CLOCK;

   always @(posedge CLOCK)
      if (BUF_WE === 1'b1)
      begin
         last_addr <= BUF_ADDR;
         last_dat <= BUF_WDATA;
      end

   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cmp(input string n, input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, x, s);
      end
   endtask

   task automatic tmo(input int w);
      if (w >= 200)
      begin
         errors++;
         $display("MISMATCH wait expected done seen %0d", w);
         conclude();
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      n = 0;
      do
      begin
         @(posedge CLOCK);
         n++;
      end
      while (PREADY !== 1'b1 && n < 200);
      tmo(n);
      rdat = PRDATA;
      slv = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic take();
      int n;
      REQ_VALID <= 1'b1;
      n = 0;
      do
      begin
         @(posedge CLOCK);
         n++;
      end
      while (REQ_READY !== 1'b1 && n < 200);
      tmo(n);
      REQ_VALID <= 1'b0;
   endtask

   task automatic job(input int n, input logic sop, input logic [7:0] be, input int ab,
                      input logic st, input logic [4:0] target_thread_id);
      int w;
      take();
      mac_u.frame(n, sop, be, ab, st, 64'h0);
      w = 0;
      do
      begin
         @(negedge CLOCK);
         w++;
      end
      while (SIG_VALID !== 1'b1 && w < 200);
      tmo(w);
      cmp("sig_tid", {27'h0, SIG_TID}, {27'h0, target_thread_id});
      apb(1'b0, OFF_COMPLETION, 32'h0);
   endtask

   initial
   begin
      repeat (10) @(posedge CLOCK);
      RST <= 1'b0;
      apb(1'b0, OFF_TEMPLATE, 32'h0);
      cmp("template", rdat, 32'h2);
      apb(1'b0, OFF_STATUS, 32'h0);
      cmp("status", rdat, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      cmp("unmapped", {31'h0, slv}, 32'h1);
      // Every byte count in both byte orders, one beat per request
      for (int e = 0; e < 2; e++)
         for (int n = 1; n <= 8; n++)
         begin
            apb(1'b1, OFF_TEMPLATE, {30'h0, 1'b1, e[0]});
            REQ_TID <= 5'(n);
            REQ_E1 <= 4'(n);
            REQ_PKT_SEQ <= 4'(n);
            job(1, 1'b0, e ? big_t[8*(8-n) +: 8] : lit_t[8*(8-n) +: 8], 0, 1'b0, 5'(n));
            cmp("word", rdat, {2'b10, 5'(n), 4'(n), 2'b00, 4'h5, 4'(n), 3'b000, 8'(n - 1)});
            cmp("addr", {24'h0, last_addr}, 32'(8 * n));
            cmp("data", last_dat[31:0], 32'h01010101);
         end
      apb(1'b1, OFF_READY_CTL, 32'h4000);
      REQ_TID <= 5'h03;
      REQ_PORT <= 5'h09;
      REQ_FAST <= 2'h1;
      REQ_E1 <= 4'h2;
      job(3, 1'b1, 8'h70, 0, 1'b0, 5'h03);
      cmp("word", rdat, {2'b11, 5'h09, 4'h0, 2'b00, 4'h5, 4'h2, 3'b000, 8'h14});
      apb(1'b0, OFF_STATUS, 32'h0);
      cmp("status", rdat, 32'h10);
      apb(1'b1, OFF_READY_CTL, 32'h2000);
      apb(1'b1, OFF_TEMPLATE, 32'h6);
      REQ_TID <= 5'h07;
      REQ_FAST <= 2'h2;
      REQ_E1 <= 4'h4;
      job(1, 1'b1, 8'h00, 0, 1'b1, 5'h07);
      cmp("word", rdat & 32'hc1ffffff, {2'b11, 5'h0, 4'h0, 2'b01, 4'h5, 4'h4, 3'b010, 8'h07});
      cmp("addr", {24'h0, last_addr}, 32'h89);
      REQ_TID <= 5'h02;
      job(2, 1'b0, 8'h00, 0, 1'b1, 5'h07);
      cmp("word", rdat & 32'hc1ffffff, {2'b10, 5'h0, 4'h8, 2'b01, 4'h5, 4'h4, 3'b010, 8'h0f});
      REQ_FAST <= 2'h0;
      REQ_TID <= 5'h01;
      REQ_E1 <= 4'h3;
      job(4, 1'b1, 8'h00, 2, 1'b1, 5'h01);
      cmp("word", rdat & 32'hfe17ff00, {2'b01, 5'h01, 4'h0, 2'b10, 4'h5, 4'h3, 11'h0});
      cmp("addr", {24'h0, last_addr}, 32'h18);
      // Header-body: header, then body latched, then body reused
      apb(1'b1, OFF_READY_CTL, 32'h0);
      REQ_FAST <= 2'h1;
      for (int t = 10; t < 13; t++)
      begin
         REQ_TID <= 5'(t);
         job(1, t == 10, 8'h00, 0, 1'b1, 5'(t < 12 ? t : 11));
         cmp("hb_id", {27'h0, rdat[29:25]}, t == 10 ? 32'h9 : 32'ha);
      end
      // Fill the queue, then hold a request against it
      apb(1'b1, OFF_TEMPLATE, 32'h2);
      repeat (4)
      begin
         take();
         mac_u.frame(1, 1'b0, 8'h00, 0, 1'b0, 64'h0);
      end
      apb(1'b0, OFF_STATUS, 32'h0);
      cmp("count", rdat & 32'h7, 32'h4);
      REQ_VALID <= 1'b1;
      k = 0;
      repeat (20)
      begin
         @(negedge CLOCK);
         k += (REQ_READY !== 1'b0);
      end
      cmp("stall", 32'(k), 32'h0);
      @(posedge CLOCK);
      REQ_VALID <= 1'b0;
      apb(1'b0, OFF_COMPLETION, 32'h0);
      take();
      mac_u.frame(1, 1'b0, 8'h00, 0, 1'b0, 64'h0);
      repeat (4) apb(1'b0, OFF_COMPLETION, 32'h0);
      apb(1'b0, OFF_STATUS, 32'h0);
      cmp("status", rdat, 32'h120);
      // Transmit enables, bidirectional then unidirectional
      TX_ACTIVE <= 1'b1;
      repeat (2) @(posedge CLOCK);
      TX_LAST_QW <= 1'b1;
      TX_LAST_BYTES <= 3'h4;
      repeat (2) @(posedge CLOCK);
      @(negedge CLOCK);
      cmp("tx_be", {24'h0, BYTE_ENABLE_N_OUT}, 32'he0);
      @(posedge CLOCK);
      TX_LAST_BYTES <= 3'h2;
      apb(1'b1, OFF_TEMPLATE, 32'h0);
      repeat (2) @(posedge CLOCK);
      @(negedge CLOCK);
      cmp("tx_unidir", {20'h0, BYTE_ENABLE_OE, BYTE_ENABLE_N_OUT[7:4]}, 32'hf08);
      @(posedge CLOCK);
      TX_ACTIVE <= 1'b0;
      repeat (3) @(posedge CLOCK);
      conclude();
   end
endmodule
